/* scwd_pkg.sv */
// package for the sensor command word decoder
`default_nettype none
package scwd_pkg;
   localparam int CW_W = 16;
   localparam int POS_W = 12;
   localparam int ORIENT_LSB = 0;
   localparam int SENSE_BIT = 2;
   localparam int AMODE_LSB = 3;
   localparam int FIND_BIT = 6;
   localparam int NOAUTO_BIT = 7;
   localparam int CONTRAST_LSB = 8;
   localparam int SUBPIX_BIT = 14;
   localparam int STATIC_BIT = 15;
   localparam logic [5:0] CONTRAST_RST = 6'h20;
   // reset word: right sensor, edge mode, output off, contrast 32
   localparam logic [15:0] CW_RST = 16'h2000;
   localparam logic [1:0] OR_RIGHT = 2'h0;
   localparam logic [1:0] OR_LEFT = 2'h2;
   localparam logic [1:0] OR_CENTRE = 2'h3;
   localparam logic [2:0] AM_OFF = 3'h0;
   localparam logic [2:0] AM_ZERO = 3'h1;
   localparam logic [2:0] AM_FULL = 3'h2;
   localparam logic [2:0] AM_LEFT = 3'h3;
   localparam logic [2:0] AM_RIGHT = 3'h4;
   localparam logic [2:0] AM_CENTRE = 3'h5;
   localparam logic [2:0] AM_WIDTH = 3'h6;
   localparam logic [2:0] AM_COVER = 3'h7;
   typedef struct packed {
      logic valid;
      logic left_seen;
      logic right_seen;
      logic [11:0] left_pos;
      logic [11:0] right_pos;
      logic [11:0] covered;
   } scwd_edges_t;
   typedef struct packed {
      logic static_thr;
      logic subpix;
      logic [5:0] min_contrast;
      logic contrast_mode;
      logic [1:0] orient;
   } scwd_cfg_t;
endpackage
`default_nettype wire

/* scwd_decoder.sv */
// sensor command word decoder and analog output source selection
`default_nettype none
// What this block does
// - Mode 5 enables analog output with centre line, mean of edges.
// - One missing edge: average seen edge with extreme on missing side.
// - Mode 6 enables analog output with rightmost minus leftmost edge.
// - Width output is width over full sensor range, per sensor.
// - Mode 7 enables analog output with covered percentage.
// - Coverage excludes gaps between edges; width includes them.
// - Left/right orientation ignores modes 3-7; output follows that edge.
// - Full scale beats zero scale, from either sensor's word.
// - Find-sensor bit resets orientation and lets sensor self-detect.
// - Find-sensor acts on rising edge only; controller rewrites zero.
// - Find-sensor honoured only while auto-switch disable is zero.
// - Auto-switch disable lets orientation be forced remotely.
// - Bits 8-13 minimum contrast, default 32, used in contrast mode.
// - Bit 14 one enables 4x sub-pixel resolution.
// - Bit 15 one static threshold, zero dynamic.
// - Orientation: 0 right, 2 left, 3 centre.
// - Bit 2: zero edge mode, one contrast mode.
// - Analog mode: 0 off, 1 zero, 2 full, 3 left, 4 right.
module scwd_decoder
   import scwd_pkg::*;
#(
   parameter int SENSORS = 2
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic [SENSORS-1:0] CW_WE,
   input wire logic [SENSORS*CW_W-1:0] CW_WDATA,
   input wire scwd_edges_t [SENSORS-1:0] EDGES,
   input wire logic [SENSORS*2-1:0] AUTO_ORIENT,
   output logic [SENSORS*CW_W-1:0] CW_RDATA,
   output scwd_cfg_t [SENSORS-1:0] CFG,
   output logic [SENSORS-1:0] FIND_START,
   output logic AOUT_EN,
   output logic [POS_W-1:0] AOUT_VAL
);
   localparam logic [POS_W-1:0] FULL = {POS_W{1'b1}};

   logic [CW_W-1:0] word_r [SENSORS];
   logic [SENSORS-1:0] find_prev_r;
   logic [1:0] orient_r [SENSORS];

   function automatic logic [2:0] amode(input logic [CW_W-1:0] w);
      return w[AMODE_LSB +: 3];
   endfunction

   // per-sensor analog value from its own word and edges
   function automatic logic [POS_W:0] sensor_val(input logic [CW_W-1:0] w, input logic [1:0] ori,
                                                 input scwd_edges_t e);
      logic [POS_W:0] sum;
      logic [POS_W-1:0] l;
      logic [POS_W-1:0] r;
      logic [2:0] m;
      l = e.left_seen ? e.left_pos : '0;
      r = e.right_seen ? e.right_pos : FULL;
      m = amode(w);
      sum = {1'b0, l} + {1'b0, r};
      sensor_val = '0;
      if (ori == OR_LEFT && m >= AM_LEFT)
         sensor_val = {1'b1, l};
      else if (ori == OR_RIGHT && m >= AM_LEFT)
         sensor_val = {1'b1, r};
      else begin
         case (m)
            AM_LEFT: sensor_val = {1'b1, l};
            AM_RIGHT: sensor_val = {1'b1, r};
            // centre is mean; missing edge uses extreme
            AM_CENTRE: sensor_val = {1'b1, sum[POS_W:1]};
            // width spans edges; ratio to full range
            AM_WIDTH: sensor_val = {1'b1, POS_W'(r - l)};
            // coverage; gaps excluded by front end count
            AM_COVER: sensor_val = {1'b1, e.covered};
            default: sensor_val = '0;
         endcase
      end
   endfunction

   always_ff @(posedge MCLK) begin
      for (int i = 0; i < SENSORS; i++) begin
         if (!RST_N)
            word_r[i] <= CW_RST;
         else if (CW_WE[i])
            word_r[i] <= CW_WDATA[i*CW_W +: CW_W];
      end
   end

   always_ff @(posedge MCLK) begin
      for (int i = 0; i < SENSORS; i++) begin
         if (!RST_N) begin
            find_prev_r[i] <= 1'b0;
            FIND_START[i] <= 1'b0;
         end else begin
            find_prev_r[i] <= word_r[i][FIND_BIT];
            // rising edge only; auto-switch enabled; start search
            FIND_START[i] <= word_r[i][FIND_BIT] & ~find_prev_r[i] & ~word_r[i][NOAUTO_BIT];
         end
      end
   end

   // orientation: forced from word when auto-switch off, else follows self-detection
   always_ff @(posedge MCLK) begin
      for (int i = 0; i < SENSORS; i++) begin
         if (!RST_N)
            orient_r[i] <= OR_RIGHT;
         else if (word_r[i][NOAUTO_BIT])
            orient_r[i] <= word_r[i][ORIENT_LSB +: 2];
         else if (FIND_START[i])
            orient_r[i] <= OR_RIGHT;
         else
            orient_r[i] <= AUTO_ORIENT[i*2 +: 2];
      end
   end

   always_ff @(posedge MCLK) begin
      for (int i = 0; i < SENSORS; i++) begin
         if (!RST_N) begin
            CFG[i] <= '{static_thr: 1'b0, subpix: 1'b0, min_contrast: CONTRAST_RST,
                        contrast_mode: 1'b0, orient: OR_RIGHT};
            CW_RDATA[i*CW_W +: CW_W] <= CW_RST;
         end else begin
            CFG[i].orient <= orient_r[i];
            CFG[i].contrast_mode <= word_r[i][SENSE_BIT];
            CFG[i].min_contrast <= word_r[i][CONTRAST_LSB +: 6];
            CFG[i].subpix <= word_r[i][SUBPIX_BIT];
            CFG[i].static_thr <= word_r[i][STATIC_BIT];
            CW_RDATA[i*CW_W +: CW_W] <= word_r[i];
         end
      end
   end

   // shared analog output; conflicting sources resolve to lowest sensor index,
   // which is why the controller should enable only one
   always_ff @(posedge MCLK) begin
      logic any_full;
      logic any_zero;
      logic found;
      logic [POS_W:0] v;
      any_full = 1'b0;
      any_zero = 1'b0;
      found = 1'b0;
      v = '0;
      for (int i = SENSORS - 1; i >= 0; i--) begin
         if (amode(word_r[i]) == AM_FULL)
            any_full = 1'b1;
         if (amode(word_r[i]) == AM_ZERO)
            any_zero = 1'b1;
         if (amode(word_r[i]) >= AM_LEFT) begin
            found = 1'b1;
            v = sensor_val(word_r[i], orient_r[i], EDGES[i]);
         end
      end
      if (!RST_N) begin
         AOUT_EN <= 1'b0;
         AOUT_VAL <= '0;
      end else if (any_full) begin
         AOUT_EN <= 1'b1;
         AOUT_VAL <= FULL;
      end else if (any_zero) begin
         AOUT_EN <= 1'b1;
         AOUT_VAL <= '0;
      end else begin
         AOUT_EN <= found & v[POS_W];
         AOUT_VAL <= v[POS_W-1:0];
      end
   end

   // a_full_wins: full scale beats every other mode
   a_full_wins: assert property (@(posedge MCLK) disable iff (!RST_N)
      (amode(word_r[0]) == AM_FULL) |=> (AOUT_EN && AOUT_VAL == FULL))
      else $error("full scale not output");
   a_zero_next: assert property (@(posedge MCLK) disable iff (!RST_N)
      (amode(word_r[0]) == AM_ZERO && amode(word_r[SENSORS-1]) != AM_FULL) |=> (AOUT_EN && AOUT_VAL == '0))
      else $error("zero scale not output");
   a_off_disabled: assert property (@(posedge MCLK) disable iff (!RST_N)
      (amode(word_r[0]) == AM_OFF && amode(word_r[SENSORS-1]) == AM_OFF) |=> !AOUT_EN)
      else $error("output enabled while off");
   a_find_edge: assert property (@(posedge MCLK) disable iff (!RST_N)
      FIND_START[0] |=> !FIND_START[0])
      else $error("find start repeated");
   a_find_gated: assert property (@(posedge MCLK) disable iff (!RST_N)
      FIND_START[0] |-> $past(!word_r[0][NOAUTO_BIT]))
      else $error("find start while auto switch disabled");
   a_forced_orient: assert property (@(posedge MCLK) disable iff (!RST_N)
      (word_r[0][NOAUTO_BIT] && $stable(word_r[0])) |=> ##1 (CFG[0].orient == $past(word_r[0][1:0], 2)))
      else $error("forced orientation not applied");
   a_contrast_cfg: assert property (@(posedge MCLK) disable iff (!RST_N)
      CFG[0].min_contrast == $past(word_r[0][CONTRAST_LSB +: 6]))
      else $error("minimum contrast mismatch");
   a_subpix_cfg: assert property (@(posedge MCLK) disable iff (!RST_N)
      CFG[0].subpix == $past(word_r[0][SUBPIX_BIT]))
      else $error("sub-pixel mismatch");
   a_thresh_cfg: assert property (@(posedge MCLK) disable iff (!RST_N)
      CFG[0].static_thr == $past(word_r[0][STATIC_BIT]))
      else $error("threshold select mismatch");
   a_word_load: assert property (@(posedge MCLK) disable iff (!RST_N)
      CW_WE[0] |=> ##1 (CW_RDATA[CW_W-1:0] == $past(CW_WDATA[CW_W-1:0], 2)))
      else $error("command word not stored");
   a_word_load_hi: assert property (@(posedge MCLK) disable iff (!RST_N)
      CW_WE[SENSORS-1] |=> ##1 (CW_RDATA[SENSORS*CW_W-1 -: CW_W] == $past(CW_WDATA[SENSORS*CW_W-1 -: CW_W], 2)))
      else $error("second command word not stored");

   // find request: bit low, then high while auto switch is enabled
   sequence s_find_low;
      !word_r[0][FIND_BIT];
   endsequence
   sequence s_find_high;
      word_r[0][FIND_BIT] && !word_r[0][NOAUTO_BIT];
   endsequence
   a_find_start: assert property (@(posedge MCLK) disable iff (!RST_N)
      s_find_low ##1 s_find_high |=> FIND_START[0])
      else $error("find start missed");
   a_find_orient: assert property (@(posedge MCLK) disable iff (!RST_N)
      (FIND_START[0] && !word_r[0][NOAUTO_BIT]) |=> (orient_r[0] == OR_RIGHT))
      else $error("find did not reset orientation");
   a_auto_orient: assert property (@(posedge MCLK) disable iff (!RST_N)
      (!FIND_START[0] && !word_r[0][NOAUTO_BIT]) |=> (orient_r[0] == $past(AUTO_ORIENT[1:0])))
      else $error("orientation not following self detection");
   a_orient_cfg: assert property (@(posedge MCLK) disable iff (!RST_N)
      CFG[0].orient == $past(orient_r[0]))
      else $error("orientation code mismatch");
   a_sense_cfg: assert property (@(posedge MCLK) disable iff (!RST_N)
      CFG[0].contrast_mode == $past(word_r[0][SENSE_BIT]))
      else $error("sensing method mismatch");

   // side orientation: sensor 0 is a source and the other word forces no scale
   sequence s_side_src;
      amode(word_r[0]) >= AM_LEFT && amode(word_r[SENSORS-1]) != AM_FULL
         && amode(word_r[SENSORS-1]) != AM_ZERO;
   endsequence
   a_side_left: assert property (@(posedge MCLK) disable iff (!RST_N)
      (s_side_src and (orient_r[0] == OR_LEFT && EDGES[0].left_seen))
      |=> (AOUT_EN && AOUT_VAL == $past(EDGES[0].left_pos)))
      else $error("left orientation not followed");
   a_side_right: assert property (@(posedge MCLK) disable iff (!RST_N)
      (s_side_src and (orient_r[0] == OR_RIGHT && EDGES[0].right_seen))
      |=> (AOUT_EN && AOUT_VAL == $past(EDGES[0].right_pos)))
      else $error("right orientation not followed");
   a_cover_out: assert property (@(posedge MCLK) disable iff (!RST_N)
      (s_side_src and (orient_r[0] == OR_CENTRE && amode(word_r[0]) == AM_COVER))
      |=> (AOUT_EN && AOUT_VAL == $past(EDGES[0].covered)))
      else $error("coverage not output");
   a_full_other: assert property (@(posedge MCLK) disable iff (!RST_N)
      (amode(word_r[SENSORS-1]) == AM_FULL) |=> (AOUT_EN && AOUT_VAL == FULL))
      else $error("full scale from other sensor not output");
   a_contrast_hi: assert property (@(posedge MCLK) disable iff (!RST_N)
      CFG[SENSORS-1].min_contrast == $past(word_r[SENSORS-1][CONTRAST_LSB +: 6]))
      else $error("second minimum contrast mismatch");
endmodule // scwd_decoder
`default_nettype wire

/* scwd_plc_model.sv */
// remote controller model that writes command words into the decoder
`default_nettype none
module scwd_plc_model
   import scwd_pkg::*;
(
   input wire logic clk,
   output logic [1:0] we,
   output logic [2*CW_W-1:0] wdata
);
   initial begin
      we = 2'h0;
      wdata = 32'h0;
   end
   // one word per write
   // callers keep one analog source, rewrite zero before find, set bit 7 before orientation
   task automatic write(input int s, input logic [15:0] w);
      @(posedge clk);
      #1;
      we[s] = 1'b1;
      wdata[s*16+:16] = w;
      @(posedge clk);
      #1;
      we[s] = 1'b0;
      // released data must not look like the last word
      wdata[s*16+:16] = ~w;
   endtask
endmodule // scwd_plc_model
`default_nettype wire

/* sensor_command_word_decoder_tb.sv */
// testbench for the sensor command word decoder
`default_nettype none
module sensor_command_word_decoder_tb
   import scwd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] we;
   logic [31:0] wdata;
   scwd_edges_t [1:0] edges;
   logic [3:0] auto_orient = 4'h0;
   logic [31:0] rdata;
   scwd_cfg_t [1:0] cfg;
   logic [1:0] find;
   logic aen;
   logic [11:0] aval;
   int num_errors = 0;
   int n_tests = 0;
   always #2.5 mclk = ~mclk;
   scwd_plc_model scwd_plc_model_inst (.clk(mclk), .we(we), .wdata(wdata));
   scwd_decoder #(.SENSORS(2)) scwd_decoder_inst (.MCLK(mclk), .RST_N(rst_n), .CW_WE(we), .CW_WDATA(wdata),
      .EDGES(edges), .AUTO_ORIENT(auto_orient), .CW_RDATA(rdata), .CFG(cfg), .FIND_START(find),
      .AOUT_EN(aen), .AOUT_VAL(aval));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (num_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // write, then let word, orientation and output stages land (forced orientation takes one edge more)
   task automatic wr(input int s, input logic [15:0] w);
      scwd_plc_model_inst.write(s, w);
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic t_fields();
      check(rdata, 32'h20002000);
      check(cfg[0].min_contrast, 32'h20);
      wr(0, 16'hFF87);
      check(cfg[0], 32'h7FF);
      check(rdata[15:0], 32'hFF87);
      wr(0, 16'h0080);
      check(cfg[0], 32'h0);
   endtask
   task automatic t_modes();
      wr(0, 16'h20AB);
      check({aen, aval}, 32'h1200);
      edges[0].right_seen = 1'b0;
      edges[0].left_pos = 12'h101;
      @(posedge mclk);
      @(posedge mclk);
      #1;
      check(aval, 32'h880);
      edges[0] = '{1'b1, 1'b1, 1'b1, 12'h100, 12'h300, 12'h180};
      wr(0, 16'h20B3);
      check({aen, aval}, 32'h1200);
      wr(0, 16'h20BB);
      check({aen, aval}, 32'h1180);
      wr(0, 16'h20BA);
      check(cfg[0].orient, 32'h2);
      check(aval, 32'h100);
      wr(0, 16'h2000);
      check(aen, 32'h0);
   endtask
   task automatic t_prio();
      wr(0, 16'h2088);
      check({aen, aval}, 32'h1000);
      wr(1, 16'h2090);
      check({aen, aval}, 32'h1FFF);
      wr(1, 16'h2000);
      check(aval, 32'h0);
      wr(0, 16'h2084);
      check(cfg[0].contrast_mode, 32'h1);
   endtask
   task automatic t_find();
      // the start pulse stands one cycle, one edge after the write
      scwd_plc_model_inst.write(0, 16'h2040);
      @(posedge mclk);
      #1;
      check(find, 32'h1);
      @(posedge mclk);
      #1;
      check(find, 32'h0);
      wr(0, 16'h2040);
      check(find, 32'h0);
      wr(0, 16'h2000);
      scwd_plc_model_inst.write(0, 16'h20C0);
      @(posedge mclk);
      #1;
      check(find, 32'h0);
   endtask
   initial begin
      edges = '{default: '0};
      edges[0] = '{1'b1, 1'b1, 1'b1, 12'h100, 12'h300, 12'h180};
      repeat (2) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      t_fields();
      t_modes();
      t_prio();
      t_find();
      complete_run();
   end
   // watchdog at 4000 cycles, well above the 63 or so cycles of the tests
   initial begin
      #20000;
      num_errors++;
      complete_run();
   end
endmodule // sensor_command_word_decoder_tb
`default_nettype wire
